// [pkg/mos_regs.svh]
// register offsets, field positions and timing constants of the output stage
`ifndef MOS_REGS_SVH
`define MOS_REGS_SVH
`define MOS_OFF_CTRL      12'h000
`define MOS_OFF_CLIP_LO   12'h004
`define MOS_OFF_CLIP_HI   12'h008
`define MOS_OFF_FMIN      12'h00C
`define MOS_OFF_FMAX      12'h010
`define MOS_OFF_DUTY_MIN  12'h014
`define MOS_OFF_DUTY_MAX  12'h018
`define MOS_OFF_PWM_BASE  12'h01C
`define MOS_OFF_STIM      12'h020
`define MOS_OFF_COMMIT    12'h024
`define MOS_OFF_STATUS    12'h028
`define MOS_OFF_OUTVAL    12'h02C
`define MOS_OFF_TRIM      12'h030
// control register fields
`define MOS_CTRL_TYPE_LSB 0
`define MOS_CTRL_CLIP_EN  2
`define MOS_CTRL_STIM_EN  3
`define MOS_CTRL_SRC1_LSB 4
`define MOS_CTRL_SRC7_LSB 8
`define MOS_CTRL_ANALOG_LSB 12
`define MOS_CTRL_TRIM_EN  16
`define MOS_CTRL_TEMP_LSB 20
`define MOS_CTRL_RESET    32'h0000_0000
// full scale of a value or percentage, 16 bits
`define MOS_FULL_SCALE    16'hFFFF
// frequency limits in hertz and system clock
`define MOS_CLK_HZ        32'd20000000
`define MOS_PWM_MIN_HZ    32'd200
`define MOS_PWM_MAX_HZ    32'd15000
`define MOS_FMIN_RESET    32'd1000
`define MOS_FMAX_RESET    32'd10000
`define MOS_PWM_RESET     32'd1000
`endif

// [pkg/mos_pkg.sv]
// types shared by the modulated output stage
package mos_pkg;
	typedef enum logic [1:0] {
		MOS_MOD_NONE,
		MOS_MOD_FREQ,
		MOS_MOD_PWM
	} mos_mod_t;

	typedef struct packed {
		logic [15:0] clip_lo;
		logic [15:0] clip_hi;
		logic [31:0] fmin;
		logic [31:0] fmax;
		logic [15:0] duty_min;
		logic [15:0] duty_max;
		logic [31:0] pwm_base;
		logic [15:0] stim;
		logic [31:0] ctrl;
	} mos_cfg_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mos_apb_req_t;
endpackage : mos_pkg

// [src/mos_nco.sv]
// phase accumulator that yields a square wave and a duty-cycle pulse
`timescale 1ns/1ps
`include "mos_regs.svh"
module mos_nco
	import mos_pkg::*;
#(
	parameter int ACC_W = 32
) (
	// clock and control
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	input  wire logic             i_run,
	// phase step per clock and duty threshold (upper 16 bits of phase)
	input  wire logic [ACC_W-1:0] i_step,
	input  wire logic [15:0]      i_duty,
	// outputs
	output logic                  o_square,
	output logic                  o_pulse
);
	logic [ACC_W-1:0] phase;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			phase <= '0;
		else if (i_ce)
			phase <= i_run ? phase + i_step : '0;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_square <= 1'b0;
			o_pulse  <= 1'b0;
		end else if (i_ce) begin
			o_square <= phase[ACC_W-1];
			// full duty keeps the pin high, zero keeps it low
			if (i_duty == `MOS_FULL_SCALE)
				o_pulse <= 1'b1;
			else
				o_pulse <= (phase[ACC_W-1 -: 16] < i_duty);
		end
	end
endmodule : mos_nco

// [src/mos_out_stage.sv]
// modulated output stage: clipping, source mapping, FM/PWM generation
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "mos_regs.svh"
module mos_out_stage
	import mos_pkg::*;
#(
	parameter int NCH = 4,
	parameter int CH_W = 16
) (
	// clock, reset, enable
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	input  wire logic               i_ce,
	// apb slave
	input  wire logic               i_psel,
	input  wire logic               i_penable,
	input  wire logic               i_pwrite,
	input  wire logic [11:0]        i_paddr,
	input  wire logic [31:0]        i_pwdata,
	input  wire logic [3:0]         i_pstrb,
	output logic      [31:0]        o_prdata,
	output logic                    o_pready,
	output logic                    o_pslverr,
	// corrected channel values and their active flags
	input  wire logic [NCH*CH_W-1:0] i_ch_value,
	input  wire logic [NCH-1:0]     i_ch_active,
	input  wire logic               i_temp_sensor_en,
	// pins and analog output value
	output logic                    o_gpio1,
	output logic                    o_gpio7,
	output logic      [15:0]        o_analog_output,
	output logic                    o_trim_active
);
	localparam int SEL_W = (NCH > 1) ? $clog2(NCH) : 1;

	mos_cfg_t shadow;
	mos_cfg_t active;
	logic     cfg_error;

	// apb: zero wait states, slverr on unmapped address
	logic apb_acc;
	logic apb_wr;
	logic mapped;
	assign apb_acc   = i_psel && i_penable;
	assign apb_wr    = apb_acc && i_pwrite;
	assign o_pready  = 1'b1;
	assign o_pslverr = apb_acc && !mapped;

	function automatic logic is_mapped(input logic [11:0] a);
		case (a)
			`MOS_OFF_CTRL, `MOS_OFF_CLIP_LO, `MOS_OFF_CLIP_HI,
			`MOS_OFF_FMIN, `MOS_OFF_FMAX, `MOS_OFF_DUTY_MIN,
			`MOS_OFF_DUTY_MAX, `MOS_OFF_PWM_BASE, `MOS_OFF_STIM,
			`MOS_OFF_COMMIT, `MOS_OFF_STATUS, `MOS_OFF_OUTVAL,
			`MOS_OFF_TRIM: is_mapped = 1'b1;
			default:       is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	function automatic logic [31:0] merge(input logic [31:0] o,
	                                      input logic [31:0] n,
	                                      input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = n[b*8 +: 8];
		merge = r;
	endfunction : merge

	assign mapped = is_mapped(i_paddr);

	// write word merged over the current contents through the read mux,
	// so that lanes without a strobe keep their old bytes
	logic [31:0] wr_word;
	assign wr_word = merge(o_prdata, i_pwdata, i_pstrb);

	// shadow settings, edited by software
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			shadow.ctrl     <= `MOS_CTRL_RESET;
			shadow.clip_lo  <= 16'h0000;
			shadow.clip_hi  <= `MOS_FULL_SCALE;
			shadow.fmin     <= `MOS_FMIN_RESET;
			shadow.fmax     <= `MOS_FMAX_RESET;
			shadow.duty_min <= 16'h0000;
			shadow.duty_max <= `MOS_FULL_SCALE;
			shadow.pwm_base <= `MOS_PWM_RESET;
			shadow.stim     <= 16'h0000;
		end else if (i_ce && apb_wr) begin
			case (i_paddr)
				`MOS_OFF_CTRL:
					shadow.ctrl <= wr_word;
				`MOS_OFF_CLIP_LO:
					shadow.clip_lo <= wr_word[15:0];
				`MOS_OFF_CLIP_HI:
					shadow.clip_hi <= wr_word[15:0];
				`MOS_OFF_FMIN:
					shadow.fmin <= wr_word;
				`MOS_OFF_FMAX:
					shadow.fmax <= wr_word;
				`MOS_OFF_DUTY_MIN:
					shadow.duty_min <= wr_word[15:0];
				`MOS_OFF_DUTY_MAX:
					shadow.duty_max <= wr_word[15:0];
				`MOS_OFF_PWM_BASE:
					shadow.pwm_base <= wr_word;
				`MOS_OFF_STIM:
					shadow.stim <= wr_word[15:0];
				default: ;
			endcase
		end
	end

	// commit copies the shadow into the working set; invalid set refused
	logic commit;
	logic cfg_ok;
	assign commit = i_ce && apb_wr && (i_paddr == `MOS_OFF_COMMIT)
		&& i_pwdata[0];
	assign cfg_ok = (shadow.pwm_base >= `MOS_PWM_MIN_HZ)
		&& (shadow.pwm_base <= `MOS_PWM_MAX_HZ)
		&& (shadow.fmin <= shadow.fmax)
		&& (shadow.clip_lo <= shadow.clip_hi);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			active.ctrl     <= `MOS_CTRL_RESET;
			active.clip_lo  <= 16'h0000;
			active.clip_hi  <= `MOS_FULL_SCALE;
			active.fmin     <= `MOS_FMIN_RESET;
			active.fmax     <= `MOS_FMAX_RESET;
			active.duty_min <= 16'h0000;
			active.duty_max <= `MOS_FULL_SCALE;
			active.pwm_base <= `MOS_PWM_RESET;
			active.stim     <= 16'h0000;
			cfg_error       <= 1'b0;
		end else if (commit) begin
			if (cfg_ok)
				active <= shadow;
			cfg_error <= !cfg_ok;
		end
	end

	// decoded working settings
	mos_mod_t         mod_type;
	logic             clip_en;
	logic             stim_en;
	logic             trim_en;
	logic [SEL_W-1:0] src1;
	logic [SEL_W-1:0] src7;
	logic [SEL_W-1:0] src_analog;
	logic [SEL_W-1:0] temp_ch;

	always_comb begin
		case (active.ctrl[`MOS_CTRL_TYPE_LSB +: 2])
			2'h1:    mod_type = MOS_MOD_FREQ;
			2'h2:    mod_type = MOS_MOD_PWM;
			default: mod_type = MOS_MOD_NONE;
		endcase
	end

	assign clip_en  = active.ctrl[`MOS_CTRL_CLIP_EN];
	assign stim_en  = active.ctrl[`MOS_CTRL_STIM_EN];
	assign trim_en  = active.ctrl[`MOS_CTRL_TRIM_EN];
	assign src1     = active.ctrl[`MOS_CTRL_SRC1_LSB +: SEL_W];
	assign src7     = active.ctrl[`MOS_CTRL_SRC7_LSB +: SEL_W];
	assign src_analog = active.ctrl[`MOS_CTRL_ANALOG_LSB +: SEL_W];
	assign temp_ch  = active.ctrl[`MOS_CTRL_TEMP_LSB +: SEL_W];

	// channel pick, clip; used for both pins and the analog output
	function automatic logic [15:0] pick(input logic [NCH*CH_W-1:0] v,
	                                     input logic [NCH-1:0] act,
	                                     input logic [SEL_W-1:0] s);
		logic [CH_W-1:0] w;
		w = v[s*CH_W +: CH_W];
		pick = act[s] ? w[CH_W-1 -: 16] : 16'h0000;
	endfunction : pick

	function automatic logic [15:0] clip(input logic [15:0] x,
	                                     input logic en,
	                                     input logic [15:0] lo,
	                                     input logic [15:0] hi);
		if (!en)
			clip = x;
		else if (x < lo)
			clip = lo;
		else if (x > hi)
			clip = hi;
		else
			clip = x;
	endfunction : clip

	// linear map of a 16-bit fraction between two 32-bit ends
	function automatic logic [31:0] lerp(input logic [31:0] a,
	                                     input logic [31:0] b,
	                                     input logic [15:0] f);
		logic [48:0] p;
		p = '0;
		if (f == `MOS_FULL_SCALE) begin
			// full scale lands exactly on the end b, no residue
			lerp = b;
		end else if (b >= a) begin
			p = {17'h00000, b - a} * {33'h0, f};
			lerp = a + p[47:16];
		end else begin
			p = {17'h00000, a - b} * {33'h0, f};
			lerp = a - p[47:16];
		end
	endfunction : lerp

	// value per pin; stimulus overrides measured input (not for the analog output)
	logic [15:0] val1;
	logic [15:0] val7;
	assign val1 = stim_en ? active.stim
		: clip(pick(i_ch_value, i_ch_active, src1), clip_en,
			active.clip_lo, active.clip_hi);
	assign val7 = stim_en ? active.stim
		: clip(pick(i_ch_value, i_ch_active, src7), clip_en,
			active.clip_lo, active.clip_hi);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			o_analog_output <= 16'h0000;
		else if (i_ce)
			o_analog_output <= clip(pick(i_ch_value, i_ch_active,
				src_analog), clip_en, active.clip_lo, active.clip_hi);
	end

	// sensor enable comes from outside this clock domain;
	// only the second flip-flop is read by logic
	logic sens_meta;
	logic sens_sync;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sens_meta <= 1'b0;
			sens_sync <= 1'b0;
		end else if (i_ce) begin
			sens_meta <= i_temp_sensor_en;
			sens_sync <= sens_meta;
		end
	end

	// trim only runs with the temperature sensor enabled and mapped
	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			o_trim_active <= 1'b0;
		else if (i_ce)
			o_trim_active <= trim_en && sens_sync
				&& i_ch_active[temp_ch];
	end

	// per-pin generators: phase step = freq * 2^32 / clk
	logic [15:0] vals   [2];
	logic [1:0]  square;
	logic [1:0]  pulse;
	logic [1:0]  pin_q;
	assign vals[0] = val1;
	assign vals[1] = val7;

	generate
		for (genvar g = 0; g < 2; g++) begin : g_pin
			logic [31:0] freq;
			logic [31:0] step;
			logic [15:0] duty;
			logic [31:0] duty_w;
			logic [63:0] num;
			always_comb begin
				if (mod_type == MOS_MOD_FREQ)
					freq = lerp(active.fmin, active.fmax, vals[g]);
				else
					freq = active.pwm_base;
				num  = {freq, 32'h0000_0000} / {32'h0, `MOS_CLK_HZ};
				step = num[31:0];
				// duty is mapped between duty_min and duty_max
				duty_w = lerp({16'h0000, active.duty_min},
					{16'h0000, active.duty_max}, vals[g]);
				duty   = duty_w[15:0];
			end
			mos_nco #(
				.ACC_W (32)
			) u_nco (
				.i_clk_sys (i_clk_sys),
				.i_rst     (i_rst),
				.i_ce      (i_ce),
				.i_run     (mod_type != MOS_MOD_NONE),
				.i_step    (step),
				.i_duty    (duty),
				.o_square  (square[g]),
				.o_pulse   (pulse[g])
			);
			always_comb begin
				case (mod_type)
					MOS_MOD_FREQ: pin_q[g] = square[g];
					MOS_MOD_PWM:  pin_q[g] = pulse[g];
					default:      pin_q[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_gpio1 <= 1'b0;
			o_gpio7 <= 1'b0;
		end else if (i_ce) begin
			o_gpio1 <= pin_q[0];
			o_gpio7 <= pin_q[1];
		end
	end

	// read mux
	always_comb begin
		case (i_paddr)
			`MOS_OFF_CTRL:     o_prdata = shadow.ctrl;
			`MOS_OFF_CLIP_LO:  o_prdata = {16'h0000, shadow.clip_lo};
			`MOS_OFF_CLIP_HI:  o_prdata = {16'h0000, shadow.clip_hi};
			`MOS_OFF_FMIN:     o_prdata = shadow.fmin;
			`MOS_OFF_FMAX:     o_prdata = shadow.fmax;
			`MOS_OFF_DUTY_MIN: o_prdata = {16'h0000, shadow.duty_min};
			`MOS_OFF_DUTY_MAX: o_prdata = {16'h0000, shadow.duty_max};
			`MOS_OFF_PWM_BASE: o_prdata = shadow.pwm_base;
			`MOS_OFF_STIM:     o_prdata = {16'h0000, shadow.stim};
			`MOS_OFF_STATUS:   o_prdata = {28'h0000000, o_trim_active,
				cfg_error, o_gpio7, o_gpio1};
			`MOS_OFF_OUTVAL:   o_prdata = {val7, val1};
			`MOS_OFF_TRIM:     o_prdata = {16'h0000, o_analog_output};
			default:           o_prdata = 32'h0000_0000;
		endcase
	end
endmodule : mos_out_stage

// [testbench/mos_out_stage_assertions.sv]
// port assertions of the modulated output stage
`timescale 1ns/1ps
module mos_out_stage_assertions (
	// clock and reset
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic        i_ce,
	// apb
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// pins
	input wire logic        i_temp_sensor_en,
	input wire logic        o_gpio1,
	input wire logic        o_gpio7,
	input wire logic [15:0] o_analog_output,
	input wire logic        o_trim_active
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	logic acc;
	logic unm;
	assign acc = i_psel && i_penable;
	assign unm = (i_paddr > 12'h030) || (i_paddr[1:0] != 2'h0);
	property p_ready;
		acc |-> o_pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_unmapped;
		acc && unm |-> o_pslverr && (o_prdata == 32'h0000_0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no slave error");
	property p_mapped;
		acc && !unm |-> !o_pslverr;
	endproperty
	a_mapped: assert property (p_mapped) else $error("spurious error");
	property p_setup;
		!i_penable |-> !o_pslverr;
	endproperty
	a_setup: assert property (p_setup) else $error("error outside access");
	property p_reset;
		@(posedge i_clk_sys) disable iff (1'b0) i_rst |=> !o_gpio1 &&
			!o_gpio7 && (o_analog_output == 16'h0000) && !o_trim_active;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared");
	property p_trim;
		o_trim_active && $past(i_ce) && $past(i_ce, 2) && $past(i_ce, 3)
			|-> $past(i_temp_sensor_en, 3);
	endproperty
	a_trim: assert property (p_trim) else $error("trim without sensor");
	property p_trim_rd;
		acc && !i_pwrite && (i_paddr == 12'h030) |->
			o_prdata[15:0] == o_analog_output;
	endproperty
	a_trim_rd: assert property (p_trim_rd) else $error("analog readback");
	property p_status;
		acc && !i_pwrite && (i_paddr == 12'h028) |-> o_prdata[0] == o_gpio1
			&& o_prdata[1] == o_gpio7 && o_prdata[3] == o_trim_active;
	endproperty
	a_status: assert property (p_status) else $error("status bits");
	c_unm: cover property (acc && unm);
	c_trim: cover property ($rose(o_trim_active));
	c_pulse: cover property ($rose(o_gpio1));
endmodule : mos_out_stage_assertions

// [testbench/mos_rx.sv]
// receiver on the pin: counts rising edges and high cycles in a window
`timescale 1ns/1ps
module mos_rx (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_win,
	input  wire logic        i_pin,
	output logic      [15:0] o_rises,
	output logic      [15:0] o_highs
);
	logic last;
	logic win_d;
	// first window cycle restarts the counts and is counted itself
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rises <= 16'h0000;
			o_highs <= 16'h0000;
		end else if (i_win && !win_d) begin
			o_rises <= {15'h0000, i_pin & ~last};
			o_highs <= {15'h0000, i_pin};
		end else if (i_win) begin
			o_rises <= o_rises + {15'h0000, i_pin & ~last};
			o_highs <= o_highs + {15'h0000, i_pin};
		end
		last  <= i_pin;
		win_d <= i_win;
	end
endmodule : mos_rx

// [testbench/tb.sv]
// self-checking bench of the modulated output stage
`timescale 1ns/1ps
`include "mos_regs.svh"
module tb;
	localparam int W = 10000;
	logic        i_clk_sys = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_ce = 1'b1;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic [63:0] i_ch_value = 64'h2000_8000_C000_1000;
	logic [3:0]  i_ch_active = 4'h7;
	logic        i_temp_sensor_en = 1'b0;
	logic        win = 1'b0;
	logic [31:0] o_prdata;
	logic        o_pready, o_pslverr, o_gpio1, o_gpio7, o_trim_active;
	logic [15:0] o_analog_output, rises, highs, rises7, highs7;
	logic [31:0] rd, ctl;
	logic        err;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          pb[4] = '{199, 200, 15001, 15000};
	always #25 i_clk_sys = ~i_clk_sys;
	mos_out_stage #(.NCH(4), .CH_W(16)) i_dut (.i_clk_sys(i_clk_sys),
		.i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.i_pstrb(4'hF), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_ch_value(i_ch_value),
		.i_ch_active(i_ch_active), .i_temp_sensor_en(i_temp_sensor_en),
		.o_gpio1(o_gpio1), .o_gpio7(o_gpio7),
		.o_analog_output(o_analog_output), .o_trim_active(o_trim_active));
	mos_rx i_rx (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_win(win),
		.i_pin(o_gpio1), .o_rises(rises), .o_highs(highs));
	mos_rx i_rx7 (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_win(win),
		.i_pin(o_gpio7), .o_rises(rises7), .o_highs(highs7));
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got, input logic [31:0] tol);
		total_checks++;
		if ((^got === 1'bx) || (got + tol < exp) || (got > exp + tol)) begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge i_clk_sys);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk_sys);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rd, 32'h0);
	endtask : rdc
	task automatic commit();
		apb(1'b1, `MOS_OFF_COMMIT, 32'h0000_0001);
		repeat (6) @(posedge i_clk_sys);
	endtask : commit
	task automatic meas(input int er, input int tr, input int eh, input int th);
		repeat (8) @(posedge i_clk_sys);
		win <= 1'b1;
		repeat (W) @(posedge i_clk_sys);
		win <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		chk("rises", er, {16'h0000, rises}, tr);
		chk("highs", eh, {16'h0000, highs}, th);
		chk("rises7", er, {16'h0000, rises7}, tr);
		chk("highs7", eh, {16'h0000, highs7}, th);
	endtask : meas
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rdc("ctrl", `MOS_OFF_CTRL, `MOS_CTRL_RESET);
		rdc("clip_hi", `MOS_OFF_CLIP_HI, 32'h0000_FFFF);
		rdc("fmin", `MOS_OFF_FMIN, `MOS_FMIN_RESET);
		rdc("pwm_base", `MOS_OFF_PWM_BASE, `MOS_PWM_RESET);
		apb(1'b0, 12'h100, 32'h0000_0000);
		chk("slverr", 32'h1, {31'h0, err}, 32'h0);
		ctl = 32'h0000_1210;
		apb(1'b1, `MOS_OFF_CTRL, ctl);
		rdc("outval", `MOS_OFF_OUTVAL, 32'h1000_1000);
		commit();
		rdc("outval", `MOS_OFF_OUTVAL, 32'h8000_C000);
		chk("analog", 32'hC000, {16'h0, o_analog_output}, 32'h0);
		apb(1'b1, `MOS_OFF_CLIP_LO, 32'h0000_2000);
		apb(1'b1, `MOS_OFF_CLIP_HI, 32'h0000_4000);
		ctl = ctl | 32'h0000_0004;
		apb(1'b1, `MOS_OFF_CTRL, ctl);
		chk("analog", 32'hC000, {16'h0, o_analog_output}, 32'h0);
		commit();
		chk("analog", 32'h4000, {16'h0, o_analog_output}, 32'h0);
		rdc("trim", `MOS_OFF_TRIM, 32'h0000_4000);
		apb(1'b1, `MOS_OFF_CTRL, ctl & 32'hFFFF_0FFF);
		commit();
		chk("analog", 32'h2000, {16'h0, o_analog_output}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `MOS_OFF_PWM_BASE, pb[i]);
			commit();
			apb(1'b0, `MOS_OFF_STATUS, 32'h0000_0000);
			chk("cfg_err", {31'h0, ~i[0]}, {31'h0, rd[2]}, 32'h0);
		end
		ctl = 32'h0000_2221;
		apb(1'b1, `MOS_OFF_CTRL, ctl);
		apb(1'b1, `MOS_OFF_FMIN, 32'd5000);
		apb(1'b1, `MOS_OFF_FMAX, 32'd15000);
		commit();
		meas(10000 * W / 20000000, 1, W / 2, W / 5);
		ctl = 32'h0000_2222;
		apb(1'b1, `MOS_OFF_CTRL, ctl);
		apb(1'b1, `MOS_OFF_PWM_BASE, 32'd10000);
		commit();
		meas(10000 * W / 20000000, 1, W * 32768 / 65536, 300);
		apb(1'b1, `MOS_OFF_CTRL, ctl | 32'h0000_0008);
		apb(1'b1, `MOS_OFF_STIM, 32'h0000_FFFF);
		commit();
		rdc("outval", `MOS_OFF_OUTVAL, 32'hFFFF_FFFF);
		meas(0, 0, W, 0);
		apb(1'b1, `MOS_OFF_DUTY_MAX, 32'h0000_0000);
		commit();
		meas(0, 0, 0, 0);
		apb(1'b1, `MOS_OFF_CTRL, 32'h0000_2200);
		commit();
		meas(0, 0, 0, 0);
		i_ce <= 1'b0;
		apb(1'b1, `MOS_OFF_STIM, 32'h0000_1234);
		rdc("stim_frozen", `MOS_OFF_STIM, 32'h0000_FFFF);
		i_ce <= 1'b1;
		i_temp_sensor_en <= 1'b1;
		apb(1'b1, `MOS_OFF_CTRL, 32'h0011_0000);
		commit();
		chk("trim_on", 32'h1, {31'h0, o_trim_active}, 32'h0);
		apb(1'b0, `MOS_OFF_STATUS, 32'h0000_0000);
		chk("status_trim", 32'h1, {31'h0, rd[3]}, 32'h0);
		i_temp_sensor_en <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		chk("trim_off", 32'h0, {31'h0, o_trim_active}, 32'h0);
		i_temp_sensor_en <= 1'b1;
		apb(1'b1, `MOS_OFF_CTRL, 32'h0031_0000);
		commit();
		chk("trim_idle", 32'h0, {31'h0, o_trim_active}, 32'h0);
		final_report();
	end
endmodule : tb
bind mos_out_stage mos_out_stage_assertions i_chk (.i_clk_sys(i_clk_sys),
	.i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_temp_sensor_en(i_temp_sensor_en), .o_gpio1(o_gpio1),
	.o_gpio7(o_gpio7), .o_analog_output(o_analog_output),
	.o_trim_active(o_trim_active));
